// File: include/rmc_params.svh
// Constants of the meter range and mode control: counts, limits, times.
// Assumes a 100 MHz core clock and converter readings of 13 bits.
`ifndef RMC_PARAMS_SVH
`define RMC_PARAMS_SVH
`define RMC_CLK_MHZ 100
`define RMC_CYC_PER_MS (32'd1000 * `RMC_CLK_MHZ)
`define RMC_TONE_HZ 2000
`define RMC_TONE_HALF_CYC (32'd500000 * `RMC_CLK_MHZ / `RMC_TONE_HZ)
`define RMC_HAZ_GATE_MS 32'd250
`define RMC_FULL_COUNT 13'd4000
`define RMC_LOW_COUNT 13'd400
`define RMC_CONT_LIMIT 13'd300
`define RMC_OVL_1010 13'd1010
`define RMC_OVL_610 13'd610
`define RMC_OVL_760 13'd760
`define RMC_VR_START_400V 3'd2
`define RMC_VR_START_4V 3'd0
`define RMC_VR_TOP 3'd3
`define RMC_OHM_TOP 3'd7
`define RMC_OHM_TOP_CUT 3'd6
`define RMC_CONT_OHM_CFG 3'd1
`define RMC_CAP_TOP 3'd7
`define RMC_CUR_AUTO_TOP 3'd1
`define RMC_CAP_T_A_MS 32'd330
`define RMC_CAP_T_B_MS 32'd1150
`define RMC_CAP_T_C_MS 32'd260
`define RMC_CAP_T_D_MS 32'd2600
`define RMC_CAP_T_E_MS 32'd26000
`define RMC_FC_UA 4'b1101
`define RMC_FC_MA 4'b1111
`define RMC_FC_A 4'b0000
`define RMC_FC_MAN1 4'b1100
`define RMC_FC_MAN2 4'b1000
`define RMC_FC_MAN3 4'b1010
`define RMC_FC_MAN4 4'b1001
`define RMC_OVF_NEG 2'b00
`define RMC_OVF_GND 2'b01
`endif

// File: include/rmc_pkg.sv
// Types of the meter range and mode control.
// Shared by the top module and the bench.
package rmc_pkg;
   typedef enum logic [2:0] {
      KIND_VOLT = 3'b000,
      KIND_MV = 3'b001,
      KIND_CUR = 3'b010,
      KIND_OHM = 3'b011,
      KIND_CAP = 3'b100,
      KIND_CONT = 3'b101
   } rmc_kind_t;
   typedef enum logic [3:0] {
      CUR_NONE = 4'b0000,
      CUR_MM_UA = 4'b0001,
      CUR_MM_MA = 4'b0010,
      CUR_MM_A = 4'b0011,
      CUR_CL_AUTO1 = 4'b0100,
      CUR_CL_AUTO2 = 4'b0101,
      CUR_CL_AUTO3 = 4'b0110,
      CUR_CL_MAN1 = 4'b0111,
      CUR_CL_MAN2 = 4'b1000,
      CUR_CL_MAN3 = 4'b1001,
      CUR_CL_MAN4 = 4'b1010
   } rmc_cur_t;
endpackage

// File: include/rmc_tone_if.sv
// Requests from the mode control to the buzzer tone generator.
// Both ends sit on the core clock.
`timescale 1ns/1ps
interface rmc_tone_if;
   logic tone_steady; // Tone for as long as held
   logic tone_pulsed; // Tone gated by the warning cadence
   logic phase; // Warning cadence, on half
   logic buzz; // Square wave to the buzzer
   modport ctrl (output tone_steady, output tone_pulsed, input phase, input buzz);
   modport gen (input tone_steady, input tone_pulsed, output phase, output buzz);
endinterface

// File: rtl/rmc_tone.sv
// Buzzer tone generator with a slow on/off cadence for warnings.
// Assumes the core clock; counts come from the top as parameters.
`timescale 1ns/1ps
`include "rmc_params.svh"
module rmc_tone #(
   parameter logic [31:0] HALF_CYC = `RMC_TONE_HALF_CYC,
   parameter logic [31:0] GATE_CYC = `RMC_HAZ_GATE_MS * `RMC_CYC_PER_MS
) (
   input wire logic CLK, // Core clock
   input wire logic RESET_N, // Asynchronous reset, active low
   rmc_tone_if.gen tif // Tone requests and outputs
);
   logic [31:0] half_q, half_d;
   logic [31:0] gate_q, gate_d;
   logic sq_q, ph_q, buzz_q;
   wire half_end = (half_q == HALF_CYC - 32'd1);
   wire gate_end = (gate_q == GATE_CYC - 32'd1);
   wire want = tif.tone_steady | (tif.tone_pulsed & ph_q);

   ////////////////////////////////////////////////////////////
   // Free running counters keep the cadence phase steady
   assign half_d = half_end ? 32'd0 : half_q + 32'd1;
   assign gate_d = gate_end ? 32'd0 : gate_q + 32'd1;

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         half_q <= 32'd0;
         gate_q <= 32'd0;
         sq_q <= 1'b0;
         ph_q <= 1'b0;
         buzz_q <= 1'b0;
      end else begin
         half_q <= half_d;
         gate_q <= gate_d;
         sq_q <= half_end ? ~sq_q : sq_q; // 2 kHz square wave
         ph_q <= gate_end ? ~ph_q : ph_q;
         buzz_q <= want & sq_q; // Silent output when not wanted
      end
   end

   assign tif.phase = ph_q;
   assign tif.buzz = buzz_q;

   property p_tone_half;
      @(posedge CLK) disable iff (!RESET_N)
      half_end |=> (sq_q != $past(sq_q));
   endproperty
   a_tone_half: assert property (p_tone_half) else $error("tone did not toggle");
endmodule

// File: rtl/rmc_top.sv
// Mode decode and range selection for a multimeter front end.
// Straps and rotary pins are asynchronous; converter signals share CLK.
`timescale 1ns/1ps
`include "rmc_params.svh"
module rmc_top #(
   parameter logic [31:0] TONE_HALF_CYC = `RMC_TONE_HALF_CYC,
   parameter logic [31:0] HAZ_GATE_CYC = `RMC_HAZ_GATE_MS * `RMC_CYC_PER_MS,
   parameter logic [31:0] CAP_CYC_A = `RMC_CAP_T_A_MS * `RMC_CYC_PER_MS,
   parameter logic [31:0] CAP_CYC_B = `RMC_CAP_T_B_MS * `RMC_CYC_PER_MS,
   parameter logic [31:0] CAP_CYC_C = `RMC_CAP_T_C_MS * `RMC_CYC_PER_MS,
   parameter logic [31:0] CAP_CYC_D = `RMC_CAP_T_D_MS * `RMC_CYC_PER_MS,
   parameter logic [31:0] CAP_CYC_E = `RMC_CAP_T_E_MS * `RMC_CYC_PER_MS
) (
   input wire logic CLK, // Core clock, 100 MHz
   input wire logic RESET_N, // Asynchronous reset, active low
   input wire rmc_pkg::rmc_kind_t MEAS_KIND, // Rotary measurement kind
   input wire logic AC_SELECT, // Rotary AC/DC select, 1 = AC
   input wire logic [3:0] FUNC_CODE, // Function code pins
   input wire logic CLAMP_STRAP_N, // Clamp strap, 0 = tied to V-
   input wire logic HAZARD_BEEP_DISABLE_N, // 0 = hazard beep off
   input wire logic [1:0] OVF_STRAP, // 00 V-, 01 ground, 1x floating
   input wire logic AMP_MAX_STRAP_N, // 0 = lower current maximum
   input wire logic TOP_OHM_DISABLE_N, // 0 = no 200 megohm range
   input wire logic ZERO_PUSH, // Zero push key, 1 = pressed
   input wire logic SHORT_DETECT, // Fast short comparator
   input wire logic HAZARD_DETECT, // Hazard level comparator
   input wire logic DISCHARGED, // Capacitor discharge complete
   input wire logic CONV_DONE, // Converter result pulse
   input wire logic [12:0] READING, // Converter magnitude count
   output logic INPUT_SEL_MV, // Route millivolt input to converter
   output logic [3:0] DIVIDER_TAP, // One-hot tap two..five
   output logic [2:0] RANGE_INDEX, // Current range index
   output rmc_pkg::rmc_cur_t CUR_MODE, // Decoded current mode
   output logic AMP_LIMIT_10A, // Ampere reading capped at 10A
   output logic CLAMP_LIMIT_1000A, // Clamp reading capped at 1000A
   output logic ZERO_ACTIVE, // Offset held and subtracted
   output logic [13:0] ZEROED_READING, // Reading minus offset, signed
   output logic OVERLOAD, // Overload indication
   output logic UNIT_BLANK, // Blank micro and milli symbols
   output logic DISCHARGE_MSG, // Show discharge message
   output logic CAP_SAMPLE, // Capacitance conversion strobe
   output logic BUZZER, // Buzzer drive
   output logic ALARM // Alarm drive, 1 = on
);
   import rmc_pkg::*;

   ////////////////////////////////////////////////////////////
   // Two-flop synchronisers for all pin inputs except CONV_DONE and READING
   logic [17:0] pin_s1_q, pin_s2_q;
   wire [17:0] pin_raw = {MEAS_KIND, AC_SELECT, FUNC_CODE, CLAMP_STRAP_N,
      HAZARD_BEEP_DISABLE_N, OVF_STRAP, AMP_MAX_STRAP_N, TOP_OHM_DISABLE_N,
      ZERO_PUSH, SHORT_DETECT, HAZARD_DETECT, DISCHARGED};

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pin_s1_q <= 18'h0_0000;
         pin_s2_q <= 18'h0_0000;
      end else begin
         pin_s1_q <= pin_raw;
         pin_s2_q <= pin_s1_q;
      end
   end

   rmc_kind_t kind;
   assign kind = rmc_kind_t'(pin_s2_q[17:15]);
   wire ac_s = pin_s2_q[14];
   wire [3:0] fc_s = pin_s2_q[13:10];
   wire clamp_s = pin_s2_q[9];
   wire hbd_s = pin_s2_q[8];
   wire [1:0] ovf_s = pin_s2_q[7:6];
   wire amp_s = pin_s2_q[5];
   wire tod_s = pin_s2_q[4];
   wire zero_s = pin_s2_q[3];
   wire short_s = pin_s2_q[2];
   wire haz_s = pin_s2_q[1];
   wire dis_s = pin_s2_q[0];

   ////////////////////////////////////////////////////////////
   // Current mode decode; clamp autos only with clamp strap at 0
   rmc_cur_t cur;
   always_comb begin
      cur = CUR_NONE;
      if (kind == KIND_CUR) begin
         unique case (fc_s)
            `RMC_FC_UA: cur = clamp_s ? CUR_MM_UA : CUR_CL_AUTO1;
            `RMC_FC_MA: cur = clamp_s ? CUR_MM_MA : CUR_CL_AUTO2;
            `RMC_FC_A: cur = clamp_s ? CUR_MM_A : CUR_CL_AUTO3;
            `RMC_FC_MAN1: cur = CUR_CL_MAN1;
            `RMC_FC_MAN2: cur = CUR_CL_MAN2;
            `RMC_FC_MAN3: cur = CUR_CL_MAN3;
            `RMC_FC_MAN4: cur = CUR_CL_MAN4;
            default: cur = CUR_NONE;
         endcase
      end
   end

   wire cur_auto = (cur != CUR_NONE) && (cur < CUR_CL_MAN1);
   wire clamp_dc = (cur >= CUR_CL_AUTO1) && !ac_s;

   ////////////////////////////////////////////////////////////
   // Range limits and start point per mode
   logic [2:0] top_idx, start_idx;
   always_comb begin
      top_idx = 3'd0;
      start_idx = 3'd0;
      unique case (kind)
         KIND_VOLT: begin
            top_idx = `RMC_VR_TOP;
            start_idx = clamp_s ? `RMC_VR_START_4V : `RMC_VR_START_400V;
         end
         KIND_OHM: top_idx = tod_s ? `RMC_OHM_TOP : `RMC_OHM_TOP_CUT;
         KIND_CAP: top_idx = `RMC_CAP_TOP;
         KIND_CUR: top_idx = cur_auto ? `RMC_CUR_AUTO_TOP : 3'd0;
         KIND_CONT: start_idx = `RMC_CONT_OHM_CFG;
         KIND_MV: top_idx = 3'd0;
         default: top_idx = 3'd0;
      endcase
   end

   // A change of kind or code restarts ranging
   logic [8:0] sel_q;
   wire [8:0] sel_now = {kind, fc_s, ac_s, clamp_s};
   wire sel_chg = (sel_now != sel_q);

   ////////////////////////////////////////////////////////////
   // Auto ranging on each conversion; continuity stays fixed
   logic [2:0] range_q, range_d;
   wire over = (READING > `RMC_FULL_COUNT);
   wire under = (READING < `RMC_LOW_COUNT);
   wire can_up = (range_q < top_idx);
   wire can_dn = (range_q > 3'd0) && (kind != KIND_CONT);
   always_comb begin
      range_d = range_q;
      if (sel_chg) begin
         range_d = start_idx;
      end else if (range_q > top_idx && kind != KIND_CONT) begin
         range_d = top_idx;
      end else if (CONV_DONE && over && can_up) begin
         range_d = range_q + 3'd1;
      end else if (CONV_DONE && under && can_dn) begin
         range_d = range_q - 3'd1;
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         range_q <= 3'd0;
         sel_q <= 9'h000;
      end else begin
         range_q <= range_d;
         sel_q <= sel_now;
      end
   end

   ////////////////////////////////////////////////////////////
   // Front end routing and limit flags
   logic [12:0] ovl_lim;
   assign ovl_lim = (ovf_s == `RMC_OVF_NEG) ? `RMC_OVL_1010 :
      (ovf_s == `RMC_OVF_GND) ? `RMC_OVL_610 :
      (ac_s ? `RMC_OVL_760 : `RMC_OVL_1010);
   wire volt_top = (kind == KIND_VOLT) && (range_q == `RMC_VR_TOP);
   wire ovl_now = volt_top ? (READING > ovl_lim) : (over && !can_up);
   logic low_ohm_q;
   wire cont_hit = (kind == KIND_CONT) && (short_s || low_ohm_q);
   wire haz_tone = haz_s && hbd_s;

   // Latched continuity reading compare
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         low_ohm_q <= 1'b0;
      end else if (kind != KIND_CONT) begin
         low_ohm_q <= 1'b0;
      end else if (CONV_DONE) begin
         low_ohm_q <= (READING < `RMC_CONT_LIMIT);
      end
   end

   ////////////////////////////////////////////////////////////
   // Zero push: offset capture in clamp DC modes only
   logic zero_d1_q, zero_on_q;
   logic [12:0] offset_q;
   wire zero_rise = zero_s && !zero_d1_q;
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         zero_d1_q <= 1'b0;
         zero_on_q <= 1'b0;
         offset_q <= 13'h0000;
      end else begin
         zero_d1_q <= zero_s;
         if (!clamp_dc || sel_chg) begin
            zero_on_q <= 1'b0;
            offset_q <= 13'h0000;
         end else if (zero_rise) begin
            zero_on_q <= ~zero_on_q;
            offset_q <= zero_on_q ? 13'h0000 : READING;
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // Discharge phase then timed capacitance conversions
   logic disch_q, samp_q;
   logic [31:0] cap_cnt_q;
   logic [31:0] cap_len;
   assign cap_len = (range_q < 3'd2) ? CAP_CYC_A :
      (range_q < 3'd4) ? CAP_CYC_B :
      (range_q == 3'd4) ? CAP_CYC_C :
      (range_q < 3'd7) ? CAP_CYC_D : CAP_CYC_E;
   wire cap_enter = sel_chg && (kind == KIND_CAP);
   wire cap_run = (kind == KIND_CAP) && !disch_q && !cap_enter; // No stale strobe on re-entry
   wire cap_end = cap_run && (cap_cnt_q >= cap_len - 32'd1);

   // Entry sets the phase and wins over a same-cycle done
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         disch_q <= 1'b0;
      end else if (cap_enter) begin
         disch_q <= 1'b1;
      end else if (dis_s || kind != KIND_CAP) begin
         disch_q <= 1'b0;
      end
   end

   // Period restarts on a range change so the new length applies
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         cap_cnt_q <= 32'd0;
         samp_q <= 1'b0;
      end else begin
         samp_q <= cap_end;
         if (!cap_run || cap_end || range_d != range_q) begin
            cap_cnt_q <= 32'd0;
         end else begin
            cap_cnt_q <= cap_cnt_q + 32'd1;
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // Tone generator and registered indications
   rmc_tone_if tif ();
   assign tif.tone_steady = cont_hit;
   assign tif.tone_pulsed = haz_tone;

   rmc_tone #(
      .HALF_CYC(TONE_HALF_CYC),
      .GATE_CYC(HAZ_GATE_CYC)
   ) u_tone (
      .CLK(CLK),
      .RESET_N(RESET_N),
      .tif(tif)
   );

   logic alarm_q, ovl_q;
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         alarm_q <= 1'b0;
         ovl_q <= 1'b0;
      end else begin
         alarm_q <= cont_hit || (haz_s && tif.phase);
         ovl_q <= ovl_now;
      end
   end

   ////////////////////////////////////////////////////////////
   // Output mapping
   logic [3:0] tap_oh;
   assign tap_oh = 4'b0001 << range_q[1:0];
   assign INPUT_SEL_MV = (kind == KIND_MV);
   assign DIVIDER_TAP = (kind == KIND_VOLT) ? tap_oh : 4'b0000;
   assign RANGE_INDEX = range_q;
   assign CUR_MODE = cur;
   assign AMP_LIMIT_10A = (cur == CUR_MM_A) && !amp_s;
   assign CLAMP_LIMIT_1000A = !amp_s && (cur == CUR_CL_AUTO1 || cur == CUR_CL_MAN4);
   assign ZERO_ACTIVE = zero_on_q;
   assign ZEROED_READING = {1'b0, READING} - {1'b0, offset_q};
   assign OVERLOAD = ovl_q;
   assign UNIT_BLANK = !clamp_s;
   assign DISCHARGE_MSG = disch_q;
   assign CAP_SAMPLE = samp_q;
   assign BUZZER = tif.buzz;
   assign ALARM = alarm_q;

   ////////////////////////////////////////////////////////////
   // Checks
   property p_mv_fixed;
      @(posedge CLK) disable iff (!RESET_N)
      (kind == KIND_MV) |-> INPUT_SEL_MV && DIVIDER_TAP == 4'b0000 && range_d == 3'd0;
   endproperty
   a_mv_fixed: assert property (p_mv_fixed) else $error("mV range not manual");

   property p_tap;
      @(posedge CLK) disable iff (!RESET_N)
      (kind == KIND_VOLT) |-> $onehot(DIVIDER_TAP) && range_d <= 3'd3;
   endproperty
   a_tap: assert property (p_tap) else $error("bad divider tap");

   property p_start;
      @(posedge CLK) disable iff (!RESET_N)
      (sel_chg && kind == KIND_VOLT) |=> range_q == ($past(clamp_s) ? 3'd0 : 3'd2);
   endproperty
   a_start: assert property (p_start) else $error("wrong start range");

   property p_beep_off;
      @(posedge CLK) disable iff (!RESET_N)
      (!hbd_s && kind == KIND_VOLT) |=> !BUZZER;
   endproperty
   a_beep_off: assert property (p_beep_off) else $error("hazard beep not silenced");

   property p_ovl;
      @(posedge CLK) disable iff (!RESET_N)
      (volt_top && ovf_s == 2'b01 && READING == 13'd611) |=> OVERLOAD;
   endproperty
   a_ovl: assert property (p_ovl) else $error("overload level wrong");

   property p_blank;
      @(posedge CLK) disable iff (!RESET_N)
      UNIT_BLANK == !clamp_s;
   endproperty
   a_blank: assert property (p_blank) else $error("unit blank wrong");

   property p_ohm_top;
      @(posedge CLK) disable iff (!RESET_N)
      (kind == KIND_OHM && !tod_s && !sel_chg) |=> range_q != 3'd7;
   endproperty
   a_ohm_top: assert property (p_ohm_top) else $error("200M range used");

   property p_step;
      @(posedge CLK) disable iff (!RESET_N)
      (!sel_chg && CONV_DONE && over && can_up && range_q <= top_idx) |=> range_q == $past(range_q) + 3'd1;
   endproperty
   a_step: assert property (p_step) else $error("no range step up");

   sequence s_cap_in;
      cap_enter && !dis_s;
   endsequence
   sequence s_disch_shown;
      DISCHARGE_MSG && !CAP_SAMPLE;
   endsequence
   property p_disch;
      @(posedge CLK) disable iff (!RESET_N)
      s_cap_in |=> s_disch_shown;
   endproperty
   a_disch: assert property (p_disch) else $error("discharge not shown");

   property p_short;
      @(posedge CLK) disable iff (!RESET_N)
      (short_s && kind == KIND_CONT) |-> ##1 ALARM;
   endproperty
   a_short: assert property (p_short) else $error("short not flagged");

   property p_zero;
      @(posedge CLK) disable iff (!RESET_N)
      (!clamp_dc) |=> !ZERO_ACTIVE && ZEROED_READING == {1'b0, READING};
   endproperty
   a_zero: assert property (p_zero) else $error("zero outside clamp DC");
endmodule

// File: sim/rmc_conv_model.sv
// Converter and discharge switch model for the range and mode control.
// Assumes the core clock; the bench asks for conversions with go and val.
`timescale 1ns/1ps
module rmc_conv_model #(
   parameter int DIS_CYC = 20 // Short on purpose, as after an external discharge
) (
   input wire logic clk, // Core clock
   input wire logic go, // Start a conversion
   input wire logic [12:0] val, // Value to convert
   input wire logic dis_on, // Device shows its discharge phase
   output logic done, // Result strobe, one cycle
   output logic [12:0] rd, // Magnitude count, held
   output logic dis_ok // Capacitor discharged
);
   int n = 0;
   initial begin
      done = 1'b0;
      rd = 13'h0000;
      dis_ok = 1'b0;
   end
   // Result one edge after the request; discharge ends only while the phase runs
   always @(posedge clk) begin
      done <= go;
      if (go) begin
         rd <= val;
      end
      n <= dis_on ? n + 1 : 0;
      dis_ok <= dis_on && n >= DIS_CYC;
   end
endmodule

// File: sim/tb_meter_range_mode_control.sv
// Self-checking bench for the meter range and mode control.
// Assumes rmc_pkg and the short counts set at the instance below.
`timescale 1ns/1ps
module tb_meter_range_mode_control;
   import rmc_pkg::*;
   localparam logic [31:0] CA = 32'h0000_000A;
   localparam logic [31:0] TH = 32'h0000_0004;
   localparam logic [31:0] GC = 32'h0000_0028;
   typedef struct {int s; logic [13:0] e;} rmc_note_t;
   logic CLK = 0, RESET_N = 0, AC_SELECT = 0, CLAMP_STRAP_N = 1, HAZARD_BEEP_DISABLE_N = 1, AMP_MAX_STRAP_N = 1;
   logic TOP_OHM_DISABLE_N = 1, ZERO_PUSH = 0, SHORT_DETECT = 0, HAZARD_DETECT = 0, go = 0, flag = 0;
   rmc_kind_t MEAS_KIND = KIND_VOLT;
   logic [3:0] FUNC_CODE = 4'h0, DIVIDER_TAP;
   logic [1:0] OVF_STRAP = 2'h2;
   logic [12:0] val = 13'h0000, READING, lim;
   logic [2:0] RANGE_INDEX;
   rmc_cur_t CUR_MODE;
   logic [13:0] ZEROED_READING;
   logic CONV_DONE, DISCHARGED, INPUT_SEL_MV, AMP_LIMIT_10A, CLAMP_LIMIT_1000A, ZERO_ACTIVE, OVERLOAD;
   logic UNIT_BLANK, DISCHARGE_MSG, CAP_SAMPLE, BUZZER, ALARM, st, r;
   int bad_count = 0, cmp_count = 0, seed = 51, nb, na, g;
   rmc_note_t q[$];
   rmc_note_t nt;
   string nms [13] = '{"RANGE_INDEX", "DIVIDER_TAP", "CUR_MODE", "OVERLOAD", "UNIT_BLANK", "INPUT_SEL_MV",
      "AMP_LIMIT_10A", "CLAMP_LIMIT_1000A", "ZERO_ACTIVE", "ZEROED_READING", "DISCHARGE_MSG", "ALARM", "flag"};
   rmc_cur_t curs [10] = '{CUR_MM_UA, CUR_MM_MA, CUR_MM_A, CUR_CL_AUTO1, CUR_CL_AUTO2, CUR_CL_AUTO3,
      CUR_CL_MAN1, CUR_CL_MAN2, CUR_CL_MAN3, CUR_CL_MAN4};
   logic [3:0] fcs [10] = '{4'hD, 4'hF, 4'h0, 4'hD, 4'hF, 4'h0, 4'hC, 4'h8, 4'hA, 4'h9};
   logic [9:0] cls = 10'h147;
   always #5 CLK = ~CLK;
   ////////////////////////////////////////////////////////////////////////////////
   // Counts shortened so tone, cadence and capacitance periods fit a short run
   rmc_top #(.TONE_HALF_CYC(TH), .HAZ_GATE_CYC(GC), .CAP_CYC_A(CA),
      .CAP_CYC_B(32'h0000_0014), .CAP_CYC_C(32'h0000_000F), .CAP_CYC_D(32'h0000_001E), .CAP_CYC_E(32'h0000_0032)
   ) i_dut (.CLK(CLK), .RESET_N(RESET_N), .MEAS_KIND(MEAS_KIND), .AC_SELECT(AC_SELECT), .FUNC_CODE(FUNC_CODE),
      .CLAMP_STRAP_N(CLAMP_STRAP_N), .HAZARD_BEEP_DISABLE_N(HAZARD_BEEP_DISABLE_N), .OVF_STRAP(OVF_STRAP),
      .AMP_MAX_STRAP_N(AMP_MAX_STRAP_N), .TOP_OHM_DISABLE_N(TOP_OHM_DISABLE_N), .ZERO_PUSH(ZERO_PUSH),
      .SHORT_DETECT(SHORT_DETECT), .HAZARD_DETECT(HAZARD_DETECT), .DISCHARGED(DISCHARGED), .CONV_DONE(CONV_DONE),
      .READING(READING), .INPUT_SEL_MV(INPUT_SEL_MV), .DIVIDER_TAP(DIVIDER_TAP), .RANGE_INDEX(RANGE_INDEX),
      .CUR_MODE(CUR_MODE), .AMP_LIMIT_10A(AMP_LIMIT_10A), .CLAMP_LIMIT_1000A(CLAMP_LIMIT_1000A),
      .ZERO_ACTIVE(ZERO_ACTIVE), .ZEROED_READING(ZEROED_READING), .OVERLOAD(OVERLOAD), .UNIT_BLANK(UNIT_BLANK),
      .DISCHARGE_MSG(DISCHARGE_MSG), .CAP_SAMPLE(CAP_SAMPLE), .BUZZER(BUZZER), .ALARM(ALARM));
   rmc_conv_model i_model (.clk(CLK), .go(go), .val(val), .dis_on(DISCHARGE_MSG), .done(CONV_DONE), .rd(READING),
      .dis_ok(DISCHARGED));
   ////////////////////////////////////////////////////////////////////////////////
   // Observed value by index, zero extended so one compare fits all
   function automatic logic [13:0] obs(int s);
      case (s)
         0: return 14'(RANGE_INDEX);
         1: return 14'(DIVIDER_TAP);
         2: return 14'(CUR_MODE);
         3: return 14'(OVERLOAD);
         4: return 14'(UNIT_BLANK);
         5: return 14'(INPUT_SEL_MV);
         6: return 14'(AMP_LIMIT_10A);
         7: return 14'(CLAMP_LIMIT_1000A);
         8: return 14'(ZERO_ACTIVE);
         9: return ZEROED_READING;
         10: return 14'(DISCHARGE_MSG);
         11: return 14'(ALARM);
         default: return 14'(flag);
      endcase
   endfunction
   task automatic results();
      $display("Checks %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic cmp(int s, logic [13:0] e);
      cmp_count++;
      if (obs(s) !== e) begin
         bad_count++;
         $display("ERROR %s expected %0h seen %0h", nms[s], e, obs(s));
      end
   endtask
   // Watcher: settled values are compared at the falling edge, oldest note first
   always @(negedge CLK) begin
      while (q.size() > 0) begin
         nt = q.pop_front();
         cmp(nt.s, nt.e);
      end
   end
   task automatic step(int n);
      repeat (n) @(posedge CLK);
   endtask
   task automatic ex(int s, logic [13:0] e);
      q.push_back('{s, e});
      step(1);
   endtask
   // One conversion; the range answers on the edge after the result strobe
   task automatic conv(logic [12:0] v);
      go <= 1'b1;
      val <= v;
      step(1);
      go <= 1'b0;
      step(3);
   endtask
   task automatic sel(rmc_kind_t k, logic ac, logic [3:0] fc, logic cl);
      MEAS_KIND <= k;
      AC_SELECT <= ac;
      FUNC_CODE <= fc;
      CLAMP_STRAP_N <= cl;
      step(5);
   endtask
   function automatic logic [12:0] over();
      return 13'h0FA1 + 13'($unsigned($random(seed)) % 190);
   endfunction
   // Counts buzzer toggles and alarm-high cycles over a window
   task automatic watch(int n);
      logic p;
      nb = 0;
      na = 0;
      p = BUZZER;
      repeat (n) begin
         @(negedge CLK);
         nb += (BUZZER !== p);
         p = BUZZER;
         na += (ALARM === 1'b1);
      end
      @(posedge CLK);
   endtask
   task automatic wait_cap(output int c);
      for (c = 0; c < 300 && CAP_SAMPLE !== 1'b1; c++) @(negedge CLK);
      if (c == 300) begin
         bad_count++;
         results();
      end
      @(negedge CLK);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      step(16);
      RESET_N <= 1'b1;
      step(6);
      ex(0, 14'h0000);
      ex(1, 14'h0001);
      ex(4, 14'h0000);
      sel(KIND_VOLT, 0, 4'h0, 0);
      ex(0, 14'h0002);
      ex(1, 14'h0004);
      ex(4, 14'h0001);
      sel(KIND_MV, 0, 4'h0, 1);
      ex(5, 14'h0001);
      ex(1, 14'h0000);
      for (int i = 0; i < 6; i++) begin
         OVF_STRAP <= (i / 2 == 0) ? 2'h0 : (i / 2 == 1) ? 2'h1 : 2'h2;
         lim = (i / 2 == 1) ? 13'h0262 : (i == 5) ? 13'h02F8 : 13'h03F2;
         sel(KIND_VOLT, i[0], 4'h0, 1);
         sel(KIND_MV, i[0], 4'h0, 1);
         sel(KIND_VOLT, i[0], 4'h0, 1);
         repeat (4) conv(over());
         ex(0, 14'h0003);
         ex(1, 14'h0008);
         conv(lim);
         ex(3, 14'h0000);
         conv(lim + 13'h0001);
         ex(3, 14'h0001);
         conv(13'h018F);
         ex(0, 14'h0002);
      end
      for (int i = 0; i < 10; i++) begin
         r = 1'($random(seed));
         AMP_MAX_STRAP_N <= r;
         sel(KIND_VOLT, 0, 4'h0, 1);
         sel(KIND_CUR, 0, fcs[i], cls[i]);
         ex(2, 14'(curs[i]));
         ex(6, 14'(!r && curs[i] == CUR_MM_A));
         ex(7, 14'(!r && (curs[i] == CUR_CL_AUTO1 || curs[i] == CUR_CL_MAN4)));
         ex(4, 14'(!cls[i]));
      end
      sel(KIND_CUR, 0, 4'hD, 0);
      conv(13'h0064);
      ZERO_PUSH <= 1'b1;
      step(5);
      ZERO_PUSH <= 1'b0;
      ex(8, 14'h0001);
      conv(13'h0096);
      ex(9, 14'h0032);
      sel(KIND_CUR, 1, 4'hD, 0);
      ZERO_PUSH <= 1'b1;
      step(5);
      ZERO_PUSH <= 1'b0;
      ex(8, 14'h0000);
      for (int i = 0; i < 2; i++) begin
         TOP_OHM_DISABLE_N <= i[0];
         sel(KIND_VOLT, 0, 4'h0, 1);
         sel(KIND_OHM, 0, 4'h0, 1);
         ex(0, 14'h0000);
         repeat (8) conv(over());
         ex(0, i[0] ? 14'h0007 : 14'h0006);
      end
      sel(KIND_CAP, 0, 4'h0, 1);
      ex(10, 14'h0001);
      for (g = 0; g < 100 && DISCHARGE_MSG !== 1'b0; g++) step(1);
      if (g == 100) begin
         bad_count++;
         results();
      end
      ex(10, 14'h0000);
      wait_cap(g);
      wait_cap(g);
      flag = (g + 1 >= int'(CA)) && (g + 1 <= int'(CA) + 1);
      @(posedge CLK);
      ex(12, 14'h0001);
      sel(KIND_CONT, 0, 4'h0, 1);
      ex(0, 14'h0001);
      SHORT_DETECT <= 1'b1;
      step(4);
      ex(11, 14'h0001);
      watch(120);
      flag = nb > 20;
      ex(12, 14'h0001);
      SHORT_DETECT <= 1'b0;
      conv(13'h012B);
      ex(11, 14'h0001);
      conv(13'h012C);
      ex(11, 14'h0000);
      for (int i = 0; i < 2; i++) begin
         sel(KIND_VOLT, 0, 4'h0, 1);
         HAZARD_BEEP_DISABLE_N <= i[0];
         HAZARD_DETECT <= 1'b1;
         step(4);
         watch(120);
         flag = (i[0] ? nb > 4 : nb == 0) && na > 10 && na < 110;
         ex(12, 14'h0001);
         HAZARD_DETECT <= 1'b0;
      end
      step(3);
      results();
   end
endmodule
